// ===== hw/sfr_pkg.sv
package sfr_pkg;

    // Register byte addresses
    localparam logic [7:0]  ADDR_CFG       = 8'h00;
    localparam logic [7:0]  ADDR_MASK      = 8'h04;
    localparam logic [7:0]  ADDR_STAT      = 8'h08;
    localparam logic [7:0]  ADDR_EVT       = 8'h0c;

    // Configuration register layout
    localparam int          CFG_PRIO_LSB   = 0;
    localparam int          CFG_PRIO_EN    = 2;
    localparam int          CFG_AUTO_LSB   = 4;
    localparam int          CFG_SIL_LSB    = 8;
    localparam int          CFG_POL_LSB    = 12;
    localparam int          CFG_W          = 16;
    localparam logic [15:0] CFG_RST        = 16'h00f0;

    // Relay order, also the mask register layout
    localparam int          RLY_PSU_LSB    = 0;
    localparam int          RLY_SB_LSB     = 2;
    localparam int          RLY_SUM        = 4;
    localparam int          RLY_W          = 5;
    localparam logic [4:0]  MASK_RST       = 5'h00;

    // Status register layout
    localparam int          STAT_ROUTE_LSB = 0;
    localparam int          STAT_BUSY_LSB  = 8;
    localparam int          STAT_PEND_LSB  = 10;
    localparam int          STAT_ALM_LSB   = 12;
    localparam int          STAT_SBALM_LSB = 16;
    localparam int          STAT_PSU_LSB   = 18;

    // Sticky event register layout
    localparam int          EVT_PSU_FAIL   = 0;
    localparam int          EVT_PSU_RET    = 2;
    localparam int          EVT_SB_ON      = 4;
    localparam int          EVT_SB_OFF     = 6;
    localparam int          EVT_ROUTE      = 8;
    localparam int          EVT_W          = 12;
    localparam logic [11:0] EVT_RST        = 12'h000;

    // Output routing codes, two bits per main group
    localparam logic [1:0]  ROUTE_PASS     = 2'h0;
    localparam logic [1:0]  ROUTE_SB1      = 2'h1;
    localparam logic [1:0]  ROUTE_SB2      = 2'h2;
    localparam logic [1:0]  ROUTE_SILENT   = 2'h3;

    // Supply threshold in millivolts (11 V)
    localparam logic [15:0] PSU_MIN_MV     = 16'h2af8;

    // Synchronised inputs: 4 main, 2 standby alarms, 2 buttons
    localparam int          SYNC_W         = 8;

    // Indicator blink timing
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

endpackage : sfr_pkg

// ===== hw/sfr_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfr_sync_if;
    logic [sfr_pkg::SYNC_W-1:0] raw;
    logic [sfr_pkg::SYNC_W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : sfr_sync_if
`default_nettype wire

// ===== hw/sfr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_sync
    import sfr_pkg::*;
(
    input  wire logic  clk_sys, // System clock
    input  wire logic  rst_n,   // Async reset, active low
    sfr_sync_if.sync   sif      // Raw pins in, clean levels out
);

    logic [SYNC_W-1:0] stg1;
    logic [SYNC_W-1:0] stg2;
    logic [SYNC_W-1:0] stg3;
    logic [SYNC_W-1:0] agree;

    assign agree = ~(stg2 ^ stg3);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stg1 <= '0;
            stg2 <= '0;
            stg3 <= '0;
        end
        else
        begin
            stg1 <= sif.raw;
            stg2 <= stg1;
            stg3 <= stg2;
        end
    end

    // A level counts only once two later stages agree
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sif.clean <= '0;
        else
            sif.clean <= (stg2 & agree) | (sif.clean & ~agree);
    end

endmodule : sfr_sync
`default_nettype wire

// ===== hw/sfr_ctrl.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfr_ctrl
    import sfr_pkg::*;
#(
    parameter int unsigned FLASH_HALF = FLASH_HALF_CYC // Blink half period
)
(
    input  wire logic        clk_sys,         // 40 MHz system clock
    input  wire logic        rst_n,           // Async reset, active low
    input  wire logic [3:0]  alarm_main,      // Main group alarm pins
    input  wire logic [1:0]  alarm_sb,        // Standby alarm pins, high
    input  wire logic [1:0]  restore_btn,     // Restore buttons, high
    input  wire logic [15:0] psu1_mv,         // Supply 1 level, mV
    input  wire logic [15:0] psu2_mv,         // Supply 2 level, mV
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error, unmapped
    output logic      [7:0]  route_sel,       // Route code per main
    output logic      [3:0]  led_red_alarm,   // Red alarm lamps
    output logic      [3:0]  led_red_standby, // Red standby lamps
    output logic      [1:0]  btn_green,       // Button green lamp
    output logic      [1:0]  btn_orange,      // Button orange lamp
    output logic      [1:0]  led_psu,         // Green supply lamps
    output logic      [4:0]  relay,           // Relay contacts
    output logic             notify           // Event pulse
);

    sfr_sync_if sif ();

    logic [3:0]       alm_m;
    logic [1:0]       sb_alm;
    logic [1:0]       btn_lvl;
    logic [1:0]       btn_prev;
    logic [1:0]       press;
    logic [1:0]       busy;
    logic [1:0]       pend;
    logic [1:0][1:0]  owner;
    logic             last_sb;
    logic [1:0]       next_busy;
    logic [1:0]       next_pend;
    logic [1:0][1:0]  next_owner;
    logic             next_last;
    logic             taken;
    logic [CFG_W-1:0] cfg;
    logic [1:0]       prio;
    logic [3:0]       cfg_auto;
    logic [3:0]       cfg_sil;
    logic [RLY_W-1:0] rly_mask;
    logic [RLY_W-1:0] rly_raw;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_set;
    logic [23:0]      blink_cnt;
    logic             blink;
    logic [1:0]       psu_fault;
    logic [1:0]       psu_fault_q;
    logic [3:0][1:0]  next_route;
    logic [3:0]       unserved;
    logic [3:0]       served;
    logic [31:0]      rd_data;
    logic             rd_err;
    logic             wr_en;

    function automatic logic is_served(input logic [1:0]      bz,
                                       input logic [1:0][1:0] own,
                                       input logic [1:0]      m);
        is_served = (bz[0] && own[0] == m) || (bz[1] && own[1] == m);
    endfunction : is_served

    function automatic logic psu_low(input logic [15:0] mv);
        psu_low = mv < PSU_MIN_MV;
    endfunction : psu_low

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    assign sif.raw = {restore_btn, alarm_sb, alarm_main};
    sfr_sync u_sync
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sif     (sif.sync)
    );

    // Polarity bit set means the pin alarms when low
    assign alm_m    = sif.clean[3:0] ^ cfg[CFG_POL_LSB +: 4];
    assign sb_alm   = sif.clean[5:4];
    assign btn_lvl  = sif.clean[7:6];
    assign press    = btn_lvl & ~btn_prev;
    assign prio     = cfg[CFG_PRIO_LSB +: 2];
    assign cfg_auto = cfg[CFG_AUTO_LSB +: 4];
    assign cfg_sil  = cfg[CFG_SIL_LSB +: 4];
    assign psu_fault = {psu_low(psu2_mv), psu_low(psu1_mv)};

    // Release first, then fill free standbys, then the priority steal
    always_comb
    begin
        next_busy  = busy;
        next_pend  = pend;
        next_owner = owner;
        next_last  = last_sb;
        taken      = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            if (next_busy[s])
            begin
                if (sb_alm[s])
                begin
                    next_busy[s] = 1'b0;
                    next_pend[s] = 1'b0;
                end
                else if (alm_m[next_owner[s]])
                    next_pend[s] = 1'b0;
                else if (cfg_auto[next_owner[s]])
                begin
                    next_busy[s] = 1'b0;
                    next_pend[s] = 1'b0;
                end
                else if (next_pend[s] && press[s])
                begin
                    next_busy[s] = 1'b0;
                    next_pend[s] = 1'b0;
                end
                else
                    next_pend[s] = 1'b1;
            end
        end
        for (int m = 0; m < 4; m++)
        begin
            if (alm_m[m] && !is_served(next_busy, next_owner, 2'(m)))
            begin
                taken = 1'b0;
                for (int s = 0; s < 2; s++)
                begin
                    if (!taken && !next_busy[s] && !sb_alm[s])
                    begin
                        next_busy[s]  = 1'b1;
                        next_pend[s]  = 1'b0;
                        next_owner[s] = 2'(m);
                        next_last     = s[0];
                        taken         = 1'b1;
                    end
                end
            end
        end
        if (cfg[CFG_PRIO_EN] && alm_m[prio] && next_busy == 2'h3 &&
            !is_served(next_busy, next_owner, prio) && !sb_alm[next_last])
        begin
            next_owner[next_last] = prio;
            next_pend[next_last]  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy     <= 2'h0;
            pend     <= 2'h0;
            owner    <= '0;
            last_sb  <= 1'b0;
            btn_prev <= 2'h0;
        end
        else
        begin
            busy     <= next_busy;
            pend     <= next_pend;
            owner    <= next_owner;
            last_sb  <= next_last;
            btn_prev <= btn_lvl;
        end
    end

    // Routing and lamp values from the held assignment
    always_comb
    begin
        for (int m = 0; m < 4; m++)
        begin
            served[m]   = is_served(busy, owner, 2'(m));
            unserved[m] = alm_m[m] && !served[m];
            if (busy[0] && owner[0] == 2'(m))
                next_route[m] = ROUTE_SB1;
            else if (busy[1] && owner[1] == 2'(m))
                next_route[m] = ROUTE_SB2;
            else if (alm_m[m] && cfg_sil[m])
                next_route[m] = ROUTE_SILENT;
            else
                next_route[m] = ROUTE_PASS;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_cnt <= 24'h000000;
            blink     <= 1'b0;
        end
        else if (blink_cnt == 24'(FLASH_HALF - 1))
        begin
            blink_cnt <= 24'h000000;
            blink     <= ~blink;
        end
        else
            blink_cnt <= blink_cnt + 24'h000001;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_sel       <= 8'h00;
            led_red_alarm   <= 4'h0;
            led_red_standby <= 4'h0;
            btn_green       <= 2'h3;
            btn_orange      <= 2'h0;
            led_psu         <= 2'h3;
        end
        else
        begin
            route_sel <= next_route;
            for (int m = 0; m < 4; m++)
            begin
                // Both lamps share one blink phase
                led_red_alarm[m]   <= unserved[m] ? blink : served[m];
                led_red_standby[m] <= unserved[m] ? blink : served[m];
            end
            btn_green  <= ~busy;
            btn_orange <= busy & (~pend | {2{blink}});
            for (int p = 0; p < 2; p++)
                led_psu[p] <= psu_fault[p] ? blink : 1'b1;
        end
    end

    // Relay drive; summary looks at the unmasked conditions of the others
    assign rly_raw[RLY_PSU_LSB +: 2] = psu_fault;
    assign rly_raw[RLY_SB_LSB +: 2]  = busy;
    assign rly_raw[RLY_SUM] = |(rly_raw[3:0] & ~rly_mask[3:0]);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            relay <= 5'h00;
        else
            relay <= rly_raw & ~rly_mask;
    end

    always_comb
    begin
        evt_set = '0;
        evt_set[EVT_PSU_FAIL +: 2] = psu_fault & ~psu_fault_q;
        evt_set[EVT_PSU_RET +: 2]  = ~psu_fault & psu_fault_q;
        evt_set[EVT_SB_ON +: 2]    = next_busy & ~busy;
        evt_set[EVT_SB_OFF +: 2]   = busy & ~next_busy;
        for (int m = 0; m < 4; m++)
            evt_set[EVT_ROUTE + m] = next_route[m] != route_sel[2*m +: 2];
    end

    assign wr_en = psel && penable && pwrite;

    // Set beats a write-one clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt         <= EVT_RST;
            psu_fault_q <= 2'h0;
            notify      <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == ADDR_EVT)
                evt <= (evt & ~pwdata[EVT_W-1:0]) | evt_set;
            else
                evt <= evt | evt_set;
            psu_fault_q <= psu_fault;
            notify      <= |evt_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg      <= CFG_RST;
            rly_mask <= MASK_RST;
        end
        else if (wr_en && paddr == ADDR_CFG)
            cfg <= pwdata[CFG_W-1:0];
        else if (wr_en && paddr == ADDR_MASK)
            rly_mask <= pwdata[RLY_W-1:0];
    end

    always_comb
    begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        unique case (paddr)
            ADDR_CFG:
                rd_data[CFG_W-1:0] = cfg;
            ADDR_MASK:
                rd_data[RLY_W-1:0] = rly_mask;
            ADDR_STAT:
            begin
                rd_data[STAT_ROUTE_LSB +: 8] = route_sel;
                rd_data[STAT_BUSY_LSB +: 2]  = busy;
                rd_data[STAT_PEND_LSB +: 2]  = pend;
                rd_data[STAT_ALM_LSB +: 4]   = alm_m;
                rd_data[STAT_SBALM_LSB +: 2] = sb_alm;
                rd_data[STAT_PSU_LSB +: 2]   = psu_fault;
            end
            ADDR_EVT:
                rd_data[EVT_W-1:0] = evt;
            default:
                rd_err = 1'b1;
        endcase
    end

    // Answer is fixed up in the setup cycle; no wait states
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (psel && !penable)
            begin
                prdata  <= pwrite ? 32'h00000000 : rd_data;
                pslverr <= rd_err;
            end
        end
    end

    // No other group waiting, else the freed standby is refilled at once
    sequence s_manual_press;
        busy[0] && pend[0] && press[0] && !alm_m[owner[0]] && !sb_alm[0] &&
        unserved == 4'h0 && !sb_alm[1];
    endsequence

    sequence s_freed_green;
        !busy[0] ##1 btn_green[0] && !btn_orange[0];
    endsequence

    a_idle_pass: assert property (
        alm_m == 4'h0 && busy == 2'h0 |=> route_sel == 8'h00 &&
        led_red_alarm == 4'h0 && led_red_standby == 4'h0)
        else $error("Idle routing or red lamps wrong");

    a_free_green: assert property (!busy[1] |=> btn_green[1])
        else $error("Unused standby button not green");

    a_first_standby: assert property (
        $rose(alm_m[0]) && busy == 2'h0 && sb_alm == 2'h0
        |=> busy[0] && owner[0] == 2'h0 ##1 route_sel[1:0] == ROUTE_SB1)
        else $error("Alarmed main not given standby 1");

    a_served_lamp: assert property (
        busy[0] && !pend[0] |=> led_red_standby[$past(owner[0])] &&
        btn_orange[0])
        else $error("Served group lamps wrong");

    // Both lamps must follow the shared blink phase, not just each other
    a_flash_pair: assert property (
        unserved != 4'h0 |=> (led_red_alarm & $past(unserved)) ==
        (led_red_standby & $past(unserved)) &&
        (led_red_alarm & $past(unserved)) ==
        ({4{$past(blink)}} & $past(unserved)))
        else $error("Unserved red lamps not in step");

    a_prio_steal: assert property (
        cfg[CFG_PRIO_EN] && busy == 2'h3 && alm_m[prio] && sb_alm == 2'h0 &&
        owner[0] != prio && owner[1] != prio &&
        alm_m[owner[0]] && alm_m[owner[1]]
        |=> owner[$past(last_sb)] == $past(prio))
        else $error("Priority group did not take latest standby");

    // A waiting group may take the freed standby in the same cycle
    a_auto_free: assert property (
        busy[1] && !alm_m[owner[1]] && cfg_auto[owner[1]] |=>
        !busy[1] || owner[1] != $past(owner[1]))
        else $error("Auto restore did not free standby");

    a_manual_hold: assert property (
        busy[0] && !alm_m[owner[0]] && !cfg_auto[owner[0]] && !sb_alm[0]
        && !pend[0] |=> busy[0] && (pend[0] || owner[0] != $past(owner[0])))
        else $error("Manual restore released standby");

    a_press_frees: assert property (s_manual_press |=> s_freed_green)
        else $error("Restore press did not free standby");

    a_sb_alarm_drop: assert property (busy[0] && sb_alm[0] |=> !busy[0])
        else $error("Alarmed standby kept serving");

    a_psu_steady: assert property (!psu_fault[1] |=> led_psu[1])
        else $error("Healthy supply lamp not lit");

    a_summary_relay: assert property (
        (rly_raw[3:0] & ~rly_mask[3:0]) != 4'h0 && !rly_mask[RLY_SUM]
        |=> relay[RLY_SUM])
        else $error("Summary relay not active");

    a_masked_relay: assert property (
        rly_mask != 5'h00 |=> (relay & $past(rly_mask)) == 5'h00)
        else $error("Masked relay closed");

    a_route_notify: assert property (
        next_route != route_sel |=> notify ##0 evt[EVT_ROUTE +: 4] != 4'h0)
        else $error("Route change raised no event");

endmodule : sfr_ctrl
`default_nettype wire

// ===== tb/sfr_decoder_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side decoders and standby sources signalling failure on pins
module sfr_decoder_model
(
    input  wire logic [3:0] fail_main,  // Main source failed
    input  wire logic [1:0] fail_sb,    // Standby source failed
    input  wire logic [3:0] pol_low,    // Pin wired active low
    output logic      [3:0] alarm_main, // Main alarm pins
    output logic      [1:0] alarm_sb    // Standby alarm pins
);
    assign alarm_main = fail_main ^ pol_low;
    assign alarm_sb   = fail_sb;
endmodule : sfr_decoder_model
`default_nettype wire

// ===== tb/standby_failover_router_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module standby_failover_router_control_tb_top;
    import sfr_pkg::*;
    localparam int FH = 4;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, notify;
    logic [7:0]  paddr, route_sel;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  alarm_main, fail_main, pol_low, led_ra, led_rs;
    logic [1:0]  alarm_sb, fail_sb, restore_btn, btn_green, btn_orange;
    logic [1:0]  led_psu;
    logic [15:0] psu1_mv, psu2_mv;
    logic [4:0]  relay;
    logic        rerr;
    int          fails, comparisons;

    sfr_decoder_model u_far (.fail_main(fail_main), .fail_sb(fail_sb),
        .pol_low(pol_low), .alarm_main(alarm_main), .alarm_sb(alarm_sb));

    sfr_ctrl #(.FLASH_HALF(FH)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .alarm_main(alarm_main), .alarm_sb(alarm_sb),
        .restore_btn(restore_btn), .psu1_mv(psu1_mv), .psu2_mv(psu2_mv),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .route_sel(route_sel), .led_red_alarm(led_ra),
        .led_red_standby(led_rs), .btn_green(btn_green),
        .btn_orange(btn_orange), .led_psu(led_psu), .relay(relay),
        .notify(notify));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task end_sim;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // Master holds the request until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            end_sim();
        end
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rd

    function automatic logic pick(input int s);
        case (s)
            0:       return led_ra[0];
            1:       return btn_orange[0];
            default: return led_psu[0];
        endcase
    endfunction : pick

    // A lamp that blinks has flipped after exactly one half period
    task blink(input int s);
        logic y;
        y = ~pick(s);
        cyc(FH);
        chk(pick(s), y);
    endtask : blink

    task do_reset;
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
    endtask : do_reset

    initial
    begin
        fails = 0; comparisons = 0; rst_n = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; restore_btn = 2'h0;
        fail_main = 4'h0; fail_sb = 2'h0; pol_low = 4'h0;
        psu1_mv = 16'h2ee0; psu2_mv = 16'h2ee0;
        do_reset();
        cyc(8);
        chk(route_sel, 8'h00);
        chk(led_ra | led_rs, 4'h0);
        chk(btn_green, 2'h3);
        rd(ADDR_CFG, CFG_RST);
        rd(ADDR_MASK, MASK_RST);
        apb(1'b0, 8'h10, 32'h0);
        chk(rerr, 1'b1);
        psu1_mv <= 16'h2af7;
        for (int n = 0; n < 12 && notify !== 1'b1; n++)
            cyc(1);
        chk(notify, 1'b1);
        cyc(2);
        chk(relay, 5'h11);
        rd(ADDR_EVT, 32'h1 << EVT_PSU_FAIL);
        blink(2);
        apb(1'b1, ADDR_MASK, 32'h1);
        cyc(3);
        chk(relay, 5'h00);
        apb(1'b1, ADDR_MASK, 32'h0);
        psu1_mv <= PSU_MIN_MV;
        cyc(8);
        chk(led_psu, 2'h3);
        cyc(FH);
        chk(led_psu, 2'h3);
        apb(1'b1, ADDR_CFG, 32'h04f5);
        fail_main <= 4'b1000;
        cyc(8);
        chk(route_sel[7:6], ROUTE_SB1);
        fail_main <= 4'b1100;
        cyc(8);
        chk(route_sel[5:4], ROUTE_SB2);
        chk(led_rs[3:2], 2'h3);
        chk({btn_orange, btn_green}, 4'hc);
        chk(relay, 5'h1c);
        fail_main <= 4'b1101;
        cyc(8);
        chk(route_sel[1:0], ROUTE_PASS);
        blink(0);
        fail_main <= 4'b1111;
        cyc(8);
        chk(route_sel[3:2], ROUTE_SB2);
        chk(route_sel[5:4], ROUTE_SILENT);
        fail_sb <= 2'b01;
        cyc(8);
        chk(route_sel[7:6], ROUTE_PASS);
        fail_main <= 4'b1101;
        cyc(8);
        chk(route_sel[3:2], ROUTE_PASS);
        chk(led_rs[1] | led_ra[1], 1'b0);
        fail_main <= 4'h0;
        fail_sb   <= 2'h0;
        pol_low   <= 4'b0010;
        do_reset();
        // Main 1 manual off, main 0 manual, main 1 active low
        apb(1'b1, ADDR_CFG, 32'h20e0);
        cyc(12);
        chk(route_sel, 8'h00);
        fail_main <= 4'b0011;
        cyc(8);
        chk(route_sel[3:0], {ROUTE_SB2, ROUTE_SB1});
        fail_main <= 4'b0010;
        cyc(8);
        chk(route_sel[1:0], ROUTE_SB1);
        blink(1);
        restore_btn <= 2'b01;
        cyc(8);
        chk(route_sel[1:0], ROUTE_PASS);
        chk({btn_green[0], led_rs[0]}, 2'b10);
        restore_btn <= 2'b00;
        cyc(4);
        rd(ADDR_STAT, {16'h0, 4'h2, 2'h0, 2'h2,
            4'h0, ROUTE_SB2, ROUTE_PASS});
        apb(1'b1, ADDR_EVT, 32'h00000fff);
        rd(ADDR_EVT, 32'h0);
        end_sim();
    end
endmodule : standby_failover_router_control_tb_top
`default_nettype wire
